// >>> src/crpc_top.sv
// Function
// - power control is 32 bits, upper zero
// - bit 0 requests power down on wait_for_interrupt
// - bits 6:4 wait_for_interrupt retention setting
// - bits 9:7 wait_for_event retention setting
// - bits 12:10 vector unit retention setting
// - zero disables retention, reset value zero
// - encodings 1-3 need 2, 8, 32 ticks
// - encodings 4-7 need 64..512 ticks
// - private selection is 32 reserved bits
// - private selection reachable only when Secure
// - private selection single-move encoding 15,6,15,8,0
// - private operation pair-move encoding 15,9,15
`timescale 1ns/1ps
`include "crpc_defs.svh"

// one idle-delay counter, repeated per retention function
module crpc_ret_counter (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic idle_i,
  input wire logic tick_i,
  input wire crpc_pkg::crpc_ret_type setting_i,
  output logic ret_o
);
  import crpc_pkg::*;

  logic [9:0] cnt_r;
  logic [9:0] limit;

  // tick threshold for the selected encoding
  always_comb begin
    case (setting_i)
      RET_T2: limit = `CRPC_TICKS_1;
      RET_T8: limit = `CRPC_TICKS_2;
      RET_T32: limit = `CRPC_TICKS_3;
      RET_T64: limit = `CRPC_TICKS_4;
      RET_T128: limit = `CRPC_TICKS_5;
      RET_T256: limit = `CRPC_TICKS_6;
      RET_T512: limit = `CRPC_TICKS_7;
      default: limit = 10'h000;
    endcase
  end

  // count saturates at the limit so a long idle never wraps back
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r <= 10'h000;
    end else if (!idle_i || setting_i == RET_OFF) begin
      cnt_r <= 10'h000;
    end else if (tick_i && cnt_r < limit) begin
      cnt_r <= cnt_r + 10'h001;
    end
  end

  // retention only once enough ticks passed, never when disabled
  assign ret_o = idle_i && (setting_i != RET_OFF) && (cnt_r >= limit);
endmodule

module crpc_top (
  // clock and reset
  input wire logic CLK_I,
  input wire logic RST_N_I,
  // coprocessor move port
  input wire logic CP_VALID_I,
  input wire crpc_pkg::crpc_cp_req_type CP_REQ_I,
  input wire logic [63:0] CP_WDATA_I,
  output logic CP_ACK_O,
  output logic CP_UNDEF_O,
  output logic [63:0] CP_RDATA_O,
  // core idle states and timer, asynchronous
  input wire logic WAIT_INT_I,
  input wire logic WAIT_EVT_I,
  input wire logic VEC_IDLE_I,
  input wire logic TIMER_TICK_I,
  // power controller indications
  output logic PWR_DOWN_REQ_O,
  output logic PWR_DOWN_NOW_O,
  output logic RET_INT_O,
  output logic RET_EVT_O,
  output logic RET_VEC_O
);
  import crpc_pkg::*;

  logic [3:0] sync1_r;
  logic [3:0] sync2_r;
  logic tick_d_r;
  logic tick_pulse;
  logic [31:0] pwr_r;
  logic [31:0] pwr_nxt;
  logic [31:0] sel_r;
  logic [63:0] opr_r;
  logic hit_pwr;
  logic hit_sel;
  logic hit_opr;
  logic ok;
  logic [63:0] rdata;
  logic ack_r;
  logic undef_r;
  logic [63:0] rdata_r;
  logic ret_int;
  logic ret_evt;
  logic ret_vec;

  // two-stage synchronisers for the idle and timer pins
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      sync1_r <= 4'h0;
      sync2_r <= 4'h0;
    end else begin
      sync1_r <= {TIMER_TICK_I, VEC_IDLE_I, WAIT_EVT_I, WAIT_INT_I};
      sync2_r <= sync1_r;
    end
  end

  // tick edge taken from the second stage only
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      tick_d_r <= 1'b0;
    end else begin
      tick_d_r <= sync2_r[3];
    end
  end
  assign tick_pulse = sync2_r[3] && !tick_d_r;

  // decode of the three reachable registers
  always_comb begin
    hit_pwr = !CP_REQ_I.pair && CP_REQ_I.coproc == `CRPC_CP_NUM && CP_REQ_I.opc1 == `CRPC_PWR_OPC1 &&
              CP_REQ_I.crn == `CRPC_PWR_CRN && CP_REQ_I.crm == `CRPC_PWR_CRM && CP_REQ_I.opc2 == `CRPC_PWR_OPC2;
    hit_sel = !CP_REQ_I.pair && CP_REQ_I.coproc == `CRPC_CP_NUM && CP_REQ_I.opc1 == `CRPC_SEL_OPC1 &&
              CP_REQ_I.crn == `CRPC_SEL_CRN && CP_REQ_I.crm == `CRPC_SEL_CRM &&
              CP_REQ_I.opc2 == `CRPC_SEL_OPC2;
    hit_opr = CP_REQ_I.pair && CP_REQ_I.coproc == `CRPC_CP_NUM && CP_REQ_I.opc1 == `CRPC_OPR_OPC1 &&
              CP_REQ_I.crm == `CRPC_OPR_CRM;
    // private registers refuse non-secure moves
    ok = hit_pwr || (CP_REQ_I.secure && (hit_sel || hit_opr));
  end

  // read mux, upper word comes back zero on single moves
  always_comb begin
    rdata = 64'h0000000000000000;
    if (hit_pwr) begin
      rdata = {32'h00000000, pwr_r};
    end else if (hit_sel) begin
      rdata = {32'h00000000, sel_r};
    end else if (hit_opr) begin
      rdata = opr_r;
    end
  end

  // only the documented fields take writes
  assign pwr_nxt = CP_WDATA_I[31:0] & `CRPC_PWR_WMASK;

  // power control register
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      pwr_r <= `CRPC_PWR_RESET;
    end else if (CP_VALID_I && CP_REQ_I.write && hit_pwr) begin
      pwr_r <= pwr_nxt;
    end
  end

  // private registers: stored, no function behind them
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      sel_r <= `CRPC_SEL_RESET;
      opr_r <= `CRPC_OPR_RESET;
    end else if (CP_VALID_I && CP_REQ_I.write && ok) begin
      if (hit_sel) begin
        sel_r <= CP_WDATA_I[31:0];
      end
      if (hit_opr) begin
        opr_r <= CP_WDATA_I;
      end
    end
  end

  // answer one cycle after the request, refused moves flag undefined
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ack_r <= 1'b0;
      undef_r <= 1'b0;
      rdata_r <= 64'h0000000000000000;
    end else begin
      ack_r <= CP_VALID_I;
      undef_r <= CP_VALID_I && !ok;
      if (CP_VALID_I && !CP_REQ_I.write && ok) begin
        rdata_r <= rdata;
      end
    end
  end
  assign CP_ACK_O = ack_r;
  assign CP_UNDEF_O = undef_r;
  assign CP_RDATA_O = rdata_r;

  // one counter per retention function
  crpc_ret_counter u_ret_int (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .idle_i(sync2_r[0]),
    .tick_i(tick_pulse),
    .setting_i(crpc_ret_type'(pwr_r[`CRPC_IRQ_RET_MSB:`CRPC_IRQ_RET_LSB])),
    .ret_o(ret_int)
  );
  crpc_ret_counter u_ret_evt (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .idle_i(sync2_r[1]),
    .tick_i(tick_pulse),
    .setting_i(crpc_ret_type'(pwr_r[`CRPC_EVT_RET_MSB:`CRPC_EVT_RET_LSB])),
    .ret_o(ret_evt)
  );
  crpc_ret_counter u_ret_vec (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .idle_i(sync2_r[2]),
    .tick_i(tick_pulse),
    .setting_i(crpc_ret_type'(pwr_r[`CRPC_VEC_RET_MSB:`CRPC_VEC_RET_LSB])),
    .ret_o(ret_vec)
  );
  assign RET_INT_O = ret_int;
  assign RET_EVT_O = ret_evt;
  assign RET_VEC_O = ret_vec;

  // request level, and request qualified by the interrupt wait
  assign PWR_DOWN_REQ_O = pwr_r[`CRPC_PWRDN_BIT];
  assign PWR_DOWN_NOW_O = pwr_r[`CRPC_PWRDN_BIT] && sync2_r[0];
endmodule

// >>> src/crpc_defs.svh
`ifndef CRPC_DEFS_SVH
`define CRPC_DEFS_SVH

// coprocessor move encodings
`define CRPC_CP_NUM 4'hf
`define CRPC_PWR_OPC1 4'h0
`define CRPC_PWR_CRN 4'hf
`define CRPC_PWR_CRM 4'h2
`define CRPC_PWR_OPC2 3'h7
`define CRPC_SEL_OPC1 4'h6
`define CRPC_SEL_CRN 4'hf
`define CRPC_SEL_CRM 4'h8
`define CRPC_SEL_OPC2 3'h0
`define CRPC_OPR_OPC1 4'h9
`define CRPC_OPR_CRM 4'hf

// power control field positions
`define CRPC_PWRDN_BIT 0
`define CRPC_IRQ_RET_LSB 4
`define CRPC_IRQ_RET_MSB 6
`define CRPC_EVT_RET_LSB 7
`define CRPC_EVT_RET_MSB 9
`define CRPC_VEC_RET_LSB 10
`define CRPC_VEC_RET_MSB 12
`define CRPC_PWR_WMASK 32'h00001ff1

// reset values
`define CRPC_PWR_RESET 32'h00000000
`define CRPC_SEL_RESET 32'h00000000
`define CRPC_OPR_RESET 64'h0000000000000000
`define CRPC_RET_OFF 3'h0

// timer ticks per retention encoding
`define CRPC_TICKS_1 10'h002
`define CRPC_TICKS_2 10'h008
`define CRPC_TICKS_3 10'h020
`define CRPC_TICKS_4 10'h040
`define CRPC_TICKS_5 10'h080
`define CRPC_TICKS_6 10'h100
`define CRPC_TICKS_7 10'h200

`endif

// >>> src/crpc_pkg.sv
package crpc_pkg;
  // one coprocessor move request
  typedef struct packed {
    logic write;
    logic pair;
    logic [3:0] coproc;
    logic [3:0] opc1;
    logic [3:0] crn;
    logic [3:0] crm;
    logic [2:0] opc2;
    logic secure;
  } crpc_cp_req_type;

  // retention field encodings
  typedef enum logic [2:0] {
    RET_OFF = 3'h0,
    RET_T2 = 3'h1,
    RET_T8 = 3'h2,
    RET_T32 = 3'h3,
    RET_T64 = 3'h4,
    RET_T128 = 3'h5,
    RET_T256 = 3'h6,
    RET_T512 = 3'h7
  } crpc_ret_type;
endpackage

// >>> tb/crpc_tick_model.sv
`timescale 1ns/1ps
// timer source; stands still unless enabled
module crpc_tick_model (
  // clock and enable
  input wire logic clk_i,
  input wire logic en_i,
  // tick output
  output logic tick_o
);
  logic [2:0] cnt_r;
  // four cycles high, four low, so a tick is never missed by the sync
  always_ff @(posedge clk_i) begin
    cnt_r <= en_i ? cnt_r + 3'h1 : 3'h0;
  end
  assign tick_o = cnt_r[2];
endmodule

// >>> tb/crpc_top_assertions.sv
`timescale 1ns/1ps
module crpc_chk (
  // clock and reset
  input wire logic CLK_I,
  input wire logic RST_N_I,
  // move port
  input wire logic CP_VALID_I,
  input wire crpc_pkg::crpc_cp_req_type CP_REQ_I,
  input wire logic [63:0] CP_WDATA_I,
  input wire logic CP_ACK_O,
  input wire logic CP_UNDEF_O,
  input wire logic [63:0] CP_RDATA_O,
  // idle and indications
  input wire logic WAIT_INT_I,
  input wire logic PWR_DOWN_REQ_O,
  input wire logic PWR_DOWN_NOW_O,
  input wire logic RET_INT_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  logic pw_hit;
  // a single move aimed at power control
  assign pw_hit = CP_VALID_I && !CP_REQ_I.pair && CP_REQ_I.coproc == 4'hf && CP_REQ_I.opc1 == 4'h0
    && CP_REQ_I.crn == 4'hf && CP_REQ_I.crm == 4'h2 && CP_REQ_I.opc2 == 3'h7;
  property p_ack; CP_VALID_I |=> CP_ACK_O; endproperty
  a_ack: assert property (p_ack) else $error("no answer");
  property p_ns_sel; CP_VALID_I && !CP_REQ_I.secure && CP_REQ_I.opc1 == 4'h6 |=> CP_UNDEF_O; endproperty
  a_ns_sel: assert property (p_ns_sel) else $error("open selection");
  property p_ns_opr; CP_VALID_I && !CP_REQ_I.secure && CP_REQ_I.opc1 == 4'h9 |=> CP_UNDEF_O; endproperty
  a_ns_opr: assert property (p_ns_opr) else $error("open operation");
  property p_hold; !CP_ACK_O || CP_UNDEF_O |-> $stable(CP_RDATA_O); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_pwr_wr; pw_hit && CP_REQ_I.write |=> PWR_DOWN_REQ_O == $past(CP_WDATA_I[0]); endproperty
  a_pwr_wr: assert property (p_pwr_wr) else $error("request bit wrong");
  property p_upper0; pw_hit && !CP_REQ_I.write |=> CP_RDATA_O[31:13] == 19'h0; endproperty
  a_upper0: assert property (p_upper0) else $error("upper bits set");
  property p_now; PWR_DOWN_NOW_O |-> PWR_DOWN_REQ_O && $past(WAIT_INT_I, 2); endproperty
  a_now: assert property (p_now) else $error("power down early");
  property p_ret_off; !WAIT_INT_I [*3] |-> !RET_INT_O; endproperty
  a_ret_off: assert property (p_ret_off) else $error("retention awake");
endmodule
bind crpc_top crpc_chk i_crpc_chk (.CLK_I(CLK_I), .RST_N_I(RST_N_I), .CP_VALID_I(CP_VALID_I),
  .CP_REQ_I(CP_REQ_I), .CP_WDATA_I(CP_WDATA_I), .CP_ACK_O(CP_ACK_O), .CP_UNDEF_O(CP_UNDEF_O),
  .CP_RDATA_O(CP_RDATA_O), .WAIT_INT_I(WAIT_INT_I), .PWR_DOWN_REQ_O(PWR_DOWN_REQ_O),
  .PWR_DOWN_NOW_O(PWR_DOWN_NOW_O), .RET_INT_O(RET_INT_O));

// >>> tb/test_core_retention_power_control.sv
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fails++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module test_core_retention_power_control;
  import crpc_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, valid = 1'b0, en = 1'b0;
  logic [2:0] idle = 3'h0;
  crpc_cp_req_type req = '0;
  logic [63:0] wdata = '0, rdata;
  logic ack, undef, tick, pdr, pdn;
  logic [2:0] ret;
  int fails = 0, total_checks = 0;
  int lim[8] = '{0, 2, 8, 32, 64, 128, 256, 512};
  // 100 ns period
  always #50 clk = ~clk;
  crpc_top i_crpc_top (.CLK_I(clk), .RST_N_I(rst_n), .CP_VALID_I(valid), .CP_REQ_I(req), .CP_WDATA_I(wdata),
    .CP_ACK_O(ack), .CP_UNDEF_O(undef), .CP_RDATA_O(rdata), .WAIT_INT_I(idle[0]), .WAIT_EVT_I(idle[1]),
    .VEC_IDLE_I(idle[2]), .TIMER_TICK_I(tick), .PWR_DOWN_REQ_O(pdr), .PWR_DOWN_NOW_O(pdn),
    .RET_INT_O(ret[0]), .RET_EVT_O(ret[1]), .RET_VEC_O(ret[2]));
  crpc_tick_model i_crpc_tick_model (.clk_i(clk), .en_i(en), .tick_o(tick));
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // one move, k = write, pair, secure; single moves only own the low word
  task automatic mv(input logic [2:0] k, input logic [3:0] o1, cn, cm, input logic [2:0] o2,
    input logic [63:0] wd, input logic und, input logic [63:0] xr);
    @(posedge clk);
    valid <= 1'b1;
    req <= crpc_cp_req_type'({k[2], k[1], 4'hf, o1, cn, cm, o2, k[0]});
    wdata <= wd;
    @(posedge clk);
    valid <= 1'b0;
    @(negedge clk);
    `CHK(ack, 1'b1)
    `CHK(undef, und)
    if (!k[2] && !und) `CHK(k[1] ? rdata : {32'h0, rdata[31:0]}, xr)
  endtask
  // registers first, then every interrupt retention setting, and encoding 1 of the other two fields, against the timer
  initial begin
    int n, f, e;
    logic pv;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    mv(3'b000, 4'h0, 4'hf, 4'h2, 3'h7, '0, 1'b0, 64'h0);
    mv(3'b001, 4'h6, 4'hf, 4'h8, 3'h0, '0, 1'b0, 64'h0);
    mv(3'b100, 4'h0, 4'hf, 4'h2, 3'h7, '1, 1'b0, '0);
    mv(3'b000, 4'h0, 4'hf, 4'h2, 3'h7, '0, 1'b0, 64'h1ff1);
    `CHK(pdr, 1'b1)
    mv(3'b100, 4'h6, 4'hf, 4'h8, 3'h0, 64'h5a5a, 1'b1, '0);
    mv(3'b101, 4'h6, 4'hf, 4'h8, 3'h0, 64'hc3c3a5a5, 1'b0, '0);
    mv(3'b001, 4'h6, 4'hf, 4'h8, 3'h0, '0, 1'b0, 64'hc3c3a5a5);
    mv(3'b000, 4'h6, 4'hf, 4'h8, 3'h0, '0, 1'b1, '0);
    mv(3'b111, 4'h9, 4'h0, 4'hf, 3'h0, 64'h0123456789abcdef, 1'b0, '0);
    mv(3'b011, 4'h9, 4'h0, 4'hf, 3'h0, '0, 1'b0, 64'h0123456789abcdef);
    mv(3'b010, 4'h9, 4'h0, 4'hf, 3'h0, '0, 1'b1, '0);
    mv(3'b001, 4'h9, 4'h0, 4'hf, 3'h0, '0, 1'b1, '0);
    for (int j = 0; j < 10; j++) begin
      f = (j < 8) ? 0 : j - 7;
      e = (j < 8) ? j : 1;
      mv(3'b100, 4'h0, 4'hf, 4'h2, 3'h7, 64'(e << (4 + 3 * f)) | 64'(f == 0), 1'b0, '0);
      @(posedge clk);
      idle[f] <= 1'b1;
      en <= 1'b1;
      n = 0;
      pv = 1'b0;
      for (int k = 0; k < 5000 && !ret[f] && !(e == 0 && k == 100); k++) begin
        @(negedge clk);
        if (tick && !pv) n++;
        pv = tick;
      end
      `CHK(ret[f], e != 0)
      if (e != 0) `CHK(n, lim[e])
      `CHK(pdn, f == 0)
      if (e != 0 && ret[f] !== 1'b1) tally_and_finish();
      @(posedge clk);
      idle[f] <= 1'b0;
      en <= 1'b0;
      repeat (4) @(negedge clk);
      `CHK(ret[f], 1'b0)
    end
    tally_and_finish();
  end
endmodule
